// ===== design/beam_loss_threshold_latch.v
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`include "loss_latch_defs.vh"

module beam_loss_threshold_latch (
    input wire core_clk,
    input wire sys_rst,
    input wire [`ADC_W-1:0] adc_a_data,
    input wire [`ADC_W-1:0] adc_b_data,
    input wire trigger_in,
    input wire [31:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg [`CHANNELS-1:0] loss_alarm_out_n,
    output reg [`CHANNELS-1:0] limit_exceeded,
    output reg trigger_echo_out,
    output reg irq
);
    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_REG_A = 3'h1;
    localparam [2:0] SEL_REG_B = 3'h2;
    localparam [2:0] SEL_RAM_A = 3'h3;
    localparam [2:0] SEL_RAM_B = 3'h4;

    localparam [2:0] REG_NONE = 3'h0;
    localparam [2:0] REG_CTRL = 3'h1;
    localparam [2:0] REG_LIMIT = 3'h2;
    localparam [2:0] REG_WINDOW = 3'h3;
    localparam [2:0] REG_STATUS = 3'h4;
    localparam [2:0] REG_IRQ_STAT = 3'h5;
    localparam [2:0] REG_IRQ_MASK = 3'h6;

    // window decode, shared by the read mux and the write path
    function [2:0] window_sel;
        input [31:0] addr;
        begin
            case (addr[31:16])
                `WIN_REG_A: window_sel = SEL_REG_A;
                `WIN_REG_B: window_sel = SEL_REG_B;
                `WIN_RAM_A: window_sel = SEL_RAM_A;
                `WIN_RAM_B: window_sel = SEL_RAM_B;
                default: window_sel = SEL_NONE;
            endcase
        end
    endfunction

    // register decode inside a bank window, shared by write strobes and read mux
    function [2:0] reg_decode;
        input [15:0] ofs;
        begin
            case (ofs)
                `OFS_CTRL: reg_decode = REG_CTRL;
                `OFS_LIMIT: reg_decode = REG_LIMIT;
                `OFS_WINDOW: reg_decode = REG_WINDOW;
                `OFS_STATUS: reg_decode = REG_STATUS;
                `OFS_IRQ_STAT: reg_decode = REG_IRQ_STAT;
                `OFS_IRQ_MASK: reg_decode = REG_IRQ_MASK;
                default: reg_decode = REG_NONE;
            endcase
        end
    endfunction

    // byte-lane merge for partial writes
    function [31:0] merge_bytes;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] be;
        integer i;
        begin
            merge_bytes = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    // samples arrive as 14-bit two's complement
    function [`SAMPLE_W-1:0] sign_extend;
        input [`ADC_W-1:0] v;
        begin
            sign_extend = {{(`SAMPLE_W-`ADC_W){v[`ADC_W-1]}}, v};
        end
    endfunction

    // saturate so a very long over-limit run never wraps back below the window
    function [15:0] sat_inc;
        input [15:0] v;
        begin
            sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
        end
    endfunction

    // status word layout, one copy per channel
    function [31:0] status_word;
        input latched;
        input alarm;
        input trig;
        input [`RAM_AW-1:0] wptr;
        begin
            status_word = 32'h00000000;
            status_word[`STAT_EXCEEDED_BIT] = latched;
            status_word[`STAT_ALARM_BIT] = alarm;
            status_word[`STAT_TRIG_BIT] = trig;
            status_word[`STAT_WPTR_LSB +: `RAM_AW] = wptr;
        end
    endfunction

    wire [2:0] sel = window_sel(avs_address);
    wire [15:0] offset = {avs_address[15:2], 2'b00};
    wire [2:0] reg_id = reg_decode(offset);
    wire bus_req = avs_read || avs_write;
    wire wr_done = avs_write && !avs_waitrequest;
    wire rd_done = avs_read && !avs_waitrequest;
    wire [`ADC_W*`CHANNELS-1:0] adc_bus = {adc_b_data, adc_a_data};

    reg [1:0] wait_cnt_q;
    reg [1:0] wait_cnt_d;
    reg [31:0] rd_mux;

    wire [31:0] bank_rd [0:`CHANNELS-1];
    wire [31:0] ram_rd [0:`CHANNELS-1];
    wire [`CHANNELS-1:0] irq_pend;
    wire [`CHANNELS-1:0] trip_now;

    genvar ch;
    generate
        for (ch = 0; ch < `CHANNELS; ch = ch + 1) begin : chan
            reg [31:0] limit_q;
            reg [15:0] window_q;
            reg [15:0] run_q;
            reg [`RAM_AW-1:0] wptr_q;
            reg latched_q;
            reg irq_stat_q;
            reg irq_mask_q;
            reg [31:0] bank_mux;

            wire bank_hit = (sel == ((ch == 0) ? SEL_REG_A : SEL_REG_B));
            wire bank_wr = wr_done && bank_hit;
            wire bank_rdclr = rd_done && bank_hit && (reg_id == REG_IRQ_STAT);
            // reset wins over a trip that falls in the same cycle
            wire reset_req = bank_wr && (reg_id == REG_CTRL)
                && avs_byteenable[0] && avs_writedata[`CTRL_RESET_BIT];
            wire [`ADC_W-1:0] raw = adc_bus[ch*`ADC_W +: `ADC_W];
            wire [31:0] sample_ext = sign_extend(raw);
            wire over = $signed(sample_ext) >= $signed(limit_q);
            wire [15:0] run_inc = sat_inc(run_q);
            wire hit = over && (run_inc >= window_q);
            wire [31:0] limit_wr = merge_bytes(limit_q, avs_writedata, avs_byteenable);
            wire [31:0] window_wr = merge_bytes({16'h0000, window_q}, avs_writedata,
                avs_byteenable);

            assign trip_now[ch] = !latched_q && hit && !reset_req;
            assign irq_pend[ch] = irq_stat_q && irq_mask_q;

            // one sample every clock while the latch is clear, no divider: the sample rate is the clock rate
            always @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    run_q <= 16'h0000;
                    wptr_q <= {`RAM_AW{1'b0}};
                    latched_q <= 1'b0;
                end else if (reset_req) begin
                    run_q <= 16'h0000;
                    latched_q <= 1'b0;
                end else if (!latched_q) begin
                    run_q <= over ? run_inc : 16'h0000;
                    wptr_q <= wptr_q + {{(`RAM_AW-1){1'b0}}, 1'b1};
                    if (hit) begin
                        latched_q <= 1'b1;
                    end
                end
            end

            // pin copies of the latch, kept as their own flops
            always @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    loss_alarm_out_n[ch] <= 1'b1;
                    limit_exceeded[ch] <= 1'b0;
                end else if (reset_req) begin
                    loss_alarm_out_n[ch] <= 1'b1;
                    limit_exceeded[ch] <= 1'b0;
                end else if (trip_now[ch]) begin
                    loss_alarm_out_n[ch] <= 1'b0;
                    limit_exceeded[ch] <= 1'b1;
                end
            end

            always @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    limit_q <= `LIMIT_RST;
                    window_q <= `WINDOW_RST;
                    irq_mask_q <= `IRQ_MASK_RST;
                    irq_stat_q <= 1'b0;
                end else begin
                    // byte lanes merge, so one field can be updated alone
                    if (bank_wr && reg_id == REG_LIMIT) begin
                        limit_q <= limit_wr;
                    end
                    if (bank_wr && reg_id == REG_WINDOW) begin
                        window_q <= window_wr[15:0];
                    end
                    if (bank_wr && reg_id == REG_IRQ_MASK && avs_byteenable[0]) begin
                        irq_mask_q <= avs_writedata[`IRQ_TRIP_BIT];
                    end
                    // a trip in the clearing cycle is kept
                    if (trip_now[ch]) begin
                        irq_stat_q <= 1'b1;
                    end else if (bank_rdclr) begin
                        irq_stat_q <= 1'b0;
                    end
                end
            end

            always @* begin
                bank_mux = 32'h00000000;
                case (reg_id)
                    REG_LIMIT: bank_mux = limit_q;
                    REG_WINDOW: bank_mux = {16'h0000, window_q};
                    REG_STATUS: bank_mux = status_word(latched_q, !loss_alarm_out_n[ch],
                        trigger_echo_out, wptr_q);
                    REG_IRQ_STAT: bank_mux[`IRQ_TRIP_BIT] = irq_stat_q;
                    REG_IRQ_MASK: bank_mux[`IRQ_TRIP_BIT] = irq_mask_q;
                    default: bank_mux = 32'h00000000;
                endcase
            end
            assign bank_rd[ch] = bank_mux;

            // software side is read-only; the ram windows ignore writes
            sample_ram ram (
                .core_clk(core_clk),
                .wr_en(!latched_q),
                .wr_addr(wptr_q),
                .wr_data(sample_ext),
                .rd_addr(avs_address[`RAM_AW+1:2]),
                .rd_data_q(ram_rd[ch])
            );
        end
    endgenerate

    always @* begin
        case (sel)
            SEL_REG_A: rd_mux = bank_rd[0];
            SEL_REG_B: rd_mux = bank_rd[1];
            SEL_RAM_A: rd_mux = ram_rd[0];
            SEL_RAM_B: rd_mux = ram_rd[1];
            default: rd_mux = 32'h00000000;
        endcase
    end

    // waitrequest stays high for two edges so the ram read data have settled
    always @* begin
        wait_cnt_d = wait_cnt_q;
        if (!avs_waitrequest) begin
            wait_cnt_d = 2'h0;
        end else if (bus_req && wait_cnt_q != `BUS_WAIT_CYCLES) begin
            wait_cnt_d = wait_cnt_q + 2'h1;
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_cnt_q <= 2'h0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            wait_cnt_q <= wait_cnt_d;
            if (avs_waitrequest && bus_req
                && wait_cnt_q == `BUS_WAIT_CYCLES) begin
                avs_waitrequest <= 1'b0;
                avs_readdata <= avs_read ? rd_mux : 32'h00000000;
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trigger_echo_out <= 1'b0;
            irq <= 1'b0;
        end else begin
            trigger_echo_out <= trigger_in;
            irq <= |irq_pend;
        end
    end
endmodule // beam_loss_threshold_latch

// ===== include/loss_latch_defs.vh
`ifndef LOSS_LATCH_DEFS_VH
`define LOSS_LATCH_DEFS_VH

// sample path
`define ADC_W 14
`define SAMPLE_W 32
`define CHANNELS 2
`define RAM_AW 11
`define RAM_DEPTH 2048

// sample clock and sample period
`define CLK_PERIOD_NS 8
`define SAMPLE_PERIOD_NS 8
`define CYCLES_PER_SAMPLE (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)

// 64K-byte windows, selected by address bits 31:16
`define WIN_REG_A 16'h43c0
`define WIN_REG_B 16'h43c1
`define WIN_RAM_A 16'h43c2
`define WIN_RAM_B 16'h43c3

// register offsets inside a register window
`define OFS_CTRL 16'h0000
`define OFS_LIMIT 16'h0004
`define OFS_WINDOW 16'h0008
`define OFS_STATUS 16'h000c
`define OFS_IRQ_STAT 16'h0010
`define OFS_IRQ_MASK 16'h0014

// field positions
`define CTRL_RESET_BIT 0
`define STAT_EXCEEDED_BIT 0
`define STAT_ALARM_BIT 1
`define STAT_TRIG_BIT 2
`define STAT_WPTR_LSB 16
`define IRQ_TRIP_BIT 0

// reset values
`define LIMIT_RST 32'h00001000
`define WINDOW_RST 16'h0001
`define IRQ_MASK_RST 1'b0

// bus answer: waitrequest drops this many edges after the request is seen
`define BUS_WAIT_CYCLES 2'h1

`endif

// ===== design/sample_ram.v
`timescale 1ns/10ps
`include "loss_latch_defs.vh"

module sample_ram (
    input wire core_clk,
    input wire wr_en,
    input wire [`RAM_AW-1:0] wr_addr,
    input wire [`SAMPLE_W-1:0] wr_data,
    input wire [`RAM_AW-1:0] rd_addr,
    output reg [`SAMPLE_W-1:0] rd_data_q
);
    reg [`SAMPLE_W-1:0] mem [0:`RAM_DEPTH-1];

    // no reset on the array, so it maps onto block ram
    always @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_q <= mem[rd_addr];
    end
endmodule // sample_ram

// ===== testbench/loss_latch_sva.sv
`timescale 1ns/10ps
`include "loss_latch_defs.vh"
module loss_latch_sva (
    input wire core_clk,
    input wire sys_rst,
    input wire trigger_in,
    input wire [31:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire [`CHANNELS-1:0] loss_alarm_out_n,
    input wire [`CHANNELS-1:0] limit_exceeded,
    input wire trigger_echo_out,
    input wire irq
);
    wire req = avs_read | avs_write;
    wire ack_w = avs_write & ~avs_waitrequest & avs_byteenable[0] & avs_writedata[0];
    wire clr_a = ack_w & (avs_address == {`WIN_REG_A, `OFS_CTRL});
    wire clr_b = ack_w & (avs_address == {`WIN_REG_B, `OFS_CTRL});
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    AST_ECHO: assert property (!$past(sys_rst) |-> trigger_echo_out == $past(trigger_in))
        else $error("echo wrong");
    AST_PAIR: assert property (loss_alarm_out_n == ~limit_exceeded)
        else $error("alarm and flag differ");
    AST_HOLD_A: assert property (limit_exceeded[0] && !clr_a |=> limit_exceeded[0])
        else $error("latch a dropped");
    AST_HOLD_B: assert property (limit_exceeded[1] && !clr_b |=> limit_exceeded[1])
        else $error("latch b dropped");
    AST_REL_A: assert property ($rose(loss_alarm_out_n[0]) |-> $past(clr_a))
        else $error("alarm a released without request");
    AST_REL_B: assert property ($rose(loss_alarm_out_n[1]) |-> $past(clr_b))
        else $error("alarm b released without request");
    AST_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long answer");
    AST_LEN: assert property ($rose(req) |-> avs_waitrequest ##1 avs_waitrequest
        ##1 !avs_waitrequest) else $error("answer timing");
    AST_RDATA: assert property (avs_waitrequest |-> $stable(avs_readdata))
        else $error("read data moved");
    AST_IRQ_FALL: assert property ($fell(irq) |-> !$past(avs_waitrequest, 2))
        else $error("irq fell without access");
endmodule // loss_latch_sva
bind beam_loss_threshold_latch loss_latch_sva chk (.core_clk, .sys_rst, .trigger_in, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .loss_alarm_out_n, .limit_exceeded, .trigger_echo_out, .irq);

// ===== testbench/avs_master.sv
`timescale 1ns/10ps
module avs_master (
    input wire core_clk,
    input wire avs_waitrequest,
    input wire [31:0] avs_readdata,
    output logic [31:0] avs_address = 32'h0,
    output logic avs_read = 1'b0,
    output logic avs_write = 1'b0,
    output logic [31:0] avs_writedata = 32'h0,
    output logic [3:0] avs_byteenable = 4'hf
);
    task automatic xfer(input bit wr, input logic [31:0] a, d, output logic [31:0] q,
        output bit to);
        int n;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        q = avs_readdata;
        to = avs_waitrequest !== 1'b0;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // released lines must not keep showing the old value
        avs_address <= ~a;
        avs_writedata <= ~d;
        @(posedge core_clk);
    endtask
endmodule // avs_master

// ===== testbench/tb.sv
`timescale 1ns/10ps
`include "loss_latch_defs.vh"
module tb;
    logic core_clk = 0;
    logic sys_rst = 1;
    logic [`ADC_W-1:0] adc_a_data = 14'h3f9c;
    logic [`ADC_W-1:0] adc_b_data = 14'h0;
    logic trigger_in = 0;
    wire [31:0] avs_address, avs_writedata, avs_readdata;
    wire avs_read, avs_write, avs_waitrequest, trigger_echo_out, irq;
    wire [3:0] avs_byteenable;
    wire [1:0] loss_alarm_out_n, limit_exceeded;
    int bad_count = 0;
    int check_count = 0;
    logic [31:0] q, s0, s1;
    localparam logic [31:0] RA = {`WIN_REG_A, 16'h0};
    localparam logic [31:0] RB = {`WIN_REG_B, 16'h0};
    always #4 core_clk = ~core_clk;
    beam_loss_threshold_latch DUT (.core_clk, .sys_rst, .adc_a_data, .adc_b_data, .trigger_in,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .loss_alarm_out_n, .limit_exceeded, .trigger_echo_out, .irq);
    avs_master m (.core_clk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable);
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic acc(input bit wr, input logic [31:0] a, d);
        bit to;
        m.xfer(wr, a, d, q, to);
        if (to) begin
            bad_count++;
            $display("MISMATCH t=%0t bus hang", $time);
            end_of_test();
        end
    endtask
    task automatic rd(input logic [31:0] a, exp);
        acc(0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic samp(input logic [13:0] v);
        adc_a_data <= v;
        @(posedge core_clk);
    endtask
    function automatic logic [31:0] ram_a(input logic [10:0] i);
        return {`WIN_RAM_A, 3'h0, i, 2'h0};
    endfunction
    initial begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 0;
        @(posedge core_clk);
        chk({28'h0, loss_alarm_out_n, limit_exceeded}, 32'hc);
        rd(RA + 32'h4, `LIMIT_RST);
        rd(RB + 32'h8, 32'h1);
        rd(RA + 32'h14, 32'h0);
        rd(32'h4400_0000, 32'h0);
        trigger_in <= 1;
        repeat (2) @(posedge core_clk);
        chk({31'h0, trigger_echo_out}, 32'h1);
        trigger_in <= 0;
        $display("test reset done");
        acc(1, RA + 32'h4, 32'hffff_ffec);
        acc(1, RA + 32'h8, 32'h3);
        acc(1, RA + 32'h14, 32'h1);
        // a sample under the limit breaks the run, equal to the limit counts
        samp(14'h3ff6);
        samp(14'h3ff6);
        samp(14'h3f9c);
        samp(14'h3fec);
        samp(14'h3ff6);
        chk({30'h0, limit_exceeded}, 32'h0);
        samp(14'h3ff1);
        adc_a_data <= 14'h0123;
        repeat (2) @(posedge core_clk);
        chk({28'h0, loss_alarm_out_n, limit_exceeded}, 32'h9);
        chk({31'h0, irq}, 32'h1);
        $display("test trip done");
        acc(0, RA + 32'hc, 32'h0);
        s0 = q;
        chk({29'h0, s0[2:0]}, 32'h3);
        rd(ram_a(s0[26:16] - 11'h1), 32'hffff_fff1);
        rd(ram_a(s0[26:16] - 11'h2), 32'hffff_fff6);
        repeat (20) @(posedge core_clk);
        rd(RA + 32'hc, s0);
        rd(RA + 32'h10, 32'h1);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        rd(RA + 32'h10, 32'h0);
        $display("test freeze done");
        adc_b_data <= 14'h1000;
        @(posedge core_clk);
        adc_b_data <= 14'h0;
        repeat (2) @(posedge core_clk);
        chk({28'h0, loss_alarm_out_n, limit_exceeded}, 32'h3);
        chk({31'h0, irq}, 32'h0);
        adc_a_data <= 14'h3f9c;
        acc(1, RA, 32'h1);
        chk({28'h0, loss_alarm_out_n, limit_exceeded}, 32'h6);
        acc(1, RB, 32'h1);
        chk({28'h0, loss_alarm_out_n, limit_exceeded}, 32'hc);
        acc(0, RA + 32'hc, 32'h0);
        s0 = q;
        repeat (10) @(posedge core_clk);
        acc(0, RA + 32'hc, 32'h0);
        s1 = q;
        chk({21'h0, s1[26:16] - s0[26:16]}, 32'he);
        repeat (2030) @(posedge core_clk);
        rd(RA + 32'hc, s0);
        $display("test resume done");
        end_of_test();
    end
endmodule // tb
